// ### rtl/otp_top.sv
// output test-pattern insertion and sync/status registers
// assumes pixel words and sync codes come from logic on clk_in;
// link_clk_in is asynchronous and paces the output words
`timescale 1ns/1ps
module otp_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [otp_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [otp_pkg::REG_W-1:0] reg_wdata_in,
	output logic [otp_pkg::REG_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// calibration status and neighbouring settings
	input wire logic [otp_pkg::CHANS-1:0] black_cal_err_in,
	input wire logic [otp_pkg::WORD_W-1:0] training_word_in,
	// pixel stream
	input wire logic [otp_pkg::LANES*otp_pkg::WORD_W-1:0] pix_words_in,
	input wire logic [otp_pkg::WORD_W-1:0] pix_sync_in,
	input wire logic pix_active_in,
	input wire logic pix_frame_start_in,
	output logic word_take_out,
	// link
	input wire logic link_clk_in,
	output logic [otp_pkg::LANES*otp_pkg::WORD_W-1:0] lane_data_out,
	output logic [otp_pkg::WORD_W-1:0] sync_data_out
);

	localparam int LW = otp_pkg::WORD_W;

	// =====================================================
	// register storage
	logic [otp_pkg::WORD_W-1:0] training_id_code_r;
	logic [otp_pkg::CHANS-1:0] black_cal_error_flags_r;
	logic [otp_pkg::REG_W-1:0] reserved_ctrl_a_r;
	logic [otp_pkg::REG_W-1:0] reserved_ctrl_b_r;
	logic [otp_pkg::REG_W-1:0] reserved_ctrl_c_r;
	logic [otp_pkg::PAT_CTRL_W-1:0] pattern_control_r;
	logic [otp_pkg::REG_W-1:0] pattern_low_lanes_0_1_r;
	logic [otp_pkg::REG_W-1:0] pattern_low_lanes_2_3_r;
	logic [7:0] pattern_high_lanes_r;
	logic [otp_pkg::REG_W-1:0] rdata_nxt;

	function automatic logic wr_hit(input logic [otp_pkg::ADDR_W-1:0] a);
		wr_hit = reg_wr_in && (reg_addr_in == a);
	endfunction : wr_hit

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			training_id_code_r <= otp_pkg::RST_TRAIN_ID;
		else if (wr_hit(otp_pkg::ADDR_TRAIN_ID))
			training_id_code_r <= reg_wdata_in[LW-1:0];
	end

	// flags follow black_cal_err_in on every clock, one cycle late
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			black_cal_error_flags_r <= '0;
		else
			black_cal_error_flags_r <= black_cal_err_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			reserved_ctrl_a_r <= otp_pkg::RST_RSVD_CTRL_A;
			reserved_ctrl_b_r <= otp_pkg::RST_RSVD_CTRL_B;
			reserved_ctrl_c_r <= otp_pkg::RST_RSVD_CTRL_C;
		end
		else
		begin
			if (wr_hit(otp_pkg::ADDR_RSVD_CTRL_A))
				reserved_ctrl_a_r <= reg_wdata_in;
			if (wr_hit(otp_pkg::ADDR_RSVD_CTRL_B))
				reserved_ctrl_b_r <= reg_wdata_in;
			if (wr_hit(otp_pkg::ADDR_RSVD_CTRL_C))
				reserved_ctrl_c_r <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			pattern_control_r <= otp_pkg::RST_PAT_CTRL;
		else if (wr_hit(otp_pkg::ADDR_PAT_CTRL))
			pattern_control_r <= reg_wdata_in[otp_pkg::PAT_CTRL_W-1:0];
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pattern_low_lanes_0_1_r <= otp_pkg::RST_PAT_LOW_01;
			pattern_low_lanes_2_3_r <= otp_pkg::RST_PAT_LOW_23;
			pattern_high_lanes_r <= otp_pkg::RST_PAT_HIGH;
		end
		else
		begin
			if (wr_hit(otp_pkg::ADDR_PAT_LOW_01))
				pattern_low_lanes_0_1_r <= reg_wdata_in;
			if (wr_hit(otp_pkg::ADDR_PAT_LOW_23))
				pattern_low_lanes_2_3_r <= reg_wdata_in;
			if (wr_hit(otp_pkg::ADDR_PAT_HIGH))
				pattern_high_lanes_r <= reg_wdata_in[7:0];
		end
	end

	// =====================================================
	// read port, data one cycle after the strobe
	always_comb
	begin
		unique case (reg_addr_in)
			otp_pkg::ADDR_TRAIN_ID: rdata_nxt = {6'h00, training_id_code_r};
			otp_pkg::ADDR_BLACK_ERR: rdata_nxt = {8'h00, black_cal_error_flags_r};
			otp_pkg::ADDR_RSVD_CTRL_A: rdata_nxt = reserved_ctrl_a_r;
			otp_pkg::ADDR_RSVD_CTRL_B: rdata_nxt = reserved_ctrl_b_r;
			otp_pkg::ADDR_PAT_CTRL: rdata_nxt = {12'h000, pattern_control_r};
			otp_pkg::ADDR_RSVD_CTRL_C: rdata_nxt = reserved_ctrl_c_r;
			otp_pkg::ADDR_PAT_LOW_01: rdata_nxt = pattern_low_lanes_0_1_r;
			otp_pkg::ADDR_PAT_LOW_23: rdata_nxt = pattern_low_lanes_2_3_r;
			otp_pkg::ADDR_PAT_HIGH: rdata_nxt = {8'h00, pattern_high_lanes_r};
			default: rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			reg_rdata_out <= '0;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in)
				reg_rdata_out <= rdata_nxt;
		end
	end

	// =====================================================
	// link clock sampling and word pacing
	logic lk_s1_r;
	logic lk_s2_r;
	logic lk_s3_r;
	logic lk_lvl_r;
	logic word_tick;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			lk_s1_r <= 1'b0;
			lk_s2_r <= 1'b0;
			lk_s3_r <= 1'b0;
		end
		else
		begin
			lk_s1_r <= link_clk_in;
			lk_s2_r <= lk_s1_r;
			lk_s3_r <= lk_s2_r;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			lk_lvl_r <= 1'b0;
		else if (lk_s2_r == lk_s3_r)
			lk_lvl_r <= lk_s3_r;
	end

	assign word_tick = (lk_s2_r == lk_s3_r) && lk_s3_r && !lk_lvl_r;
	assign word_take_out = word_tick;

	// =====================================================
	// mode decode
	logic pat_en;
	logic prbs_en;
	logic framed;
	logic test_on;
	logic test_on_d_r;
	logic restart;
	otp_pkg::otp_mode_e mode;

	assign pat_en = pattern_control_r[otp_pkg::BIT_PAT_EN];
	assign prbs_en = pattern_control_r[otp_pkg::BIT_PRBS_EN];
	assign framed = pattern_control_r[otp_pkg::BIT_PAT_FRAMED];
	assign test_on = pat_en || prbs_en;

	always_comb
	begin
		if (prbs_en)
			mode = otp_pkg::OTP_MODE_PRBS;
		else if (pattern_control_r[otp_pkg::BIT_PAT_INC])
			mode = otp_pkg::OTP_MODE_INC;
		else
			mode = otp_pkg::OTP_MODE_CONST;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			test_on_d_r <= 1'b0;
		else
			test_on_d_r <= test_on;
	end

	// sequences restart when enabled, and per frame when framed
	assign restart = (test_on && !test_on_d_r) || (framed && pix_frame_start_in && word_tick);

	// =====================================================
	// lane generators
	logic [LW-1:0] lane_base [otp_pkg::LANES];
	logic [LW-1:0] lane_word [otp_pkg::LANES];

	assign lane_base[0] = {pattern_high_lanes_r[1:0], pattern_low_lanes_0_1_r[7:0]};
	assign lane_base[1] = {pattern_high_lanes_r[3:2], pattern_low_lanes_0_1_r[15:8]};
	assign lane_base[2] = {pattern_high_lanes_r[5:4], pattern_low_lanes_2_3_r[7:0]};
	assign lane_base[3] = {pattern_high_lanes_r[7:6], pattern_low_lanes_2_3_r[15:8]};

	genvar gi;
	generate
		for (gi = 0; gi < otp_pkg::LANES; gi++)
		begin : g_lane
			otp_lane_if lane_if ();
			assign lane_if.mode = mode;
			assign lane_if.base = lane_base[gi];
			assign lane_if.restart = restart;
			// unframed patterns run on every word, framed only in active data
			assign lane_if.step = word_tick && test_on && (!framed || pix_active_in);
			assign lane_word[gi] = lane_if.word;
			otp_lane_gen u_gen (
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.lane(lane_if.gen)
			);
		end
	endgenerate

	// =====================================================
	// output word selection, one word per rising link edge
	logic [otp_pkg::LANES*LW-1:0] lanes_nxt;
	logic [LW-1:0] sync_nxt;

	always_comb
	begin
		lanes_nxt = pix_words_in;
		sync_nxt = pix_sync_in;
		if (test_on)
		begin
			if (!framed)
			begin
				for (int i = 0; i < otp_pkg::LANES; i++)
					lanes_nxt[i*LW +: LW] = lane_word[i];
				sync_nxt = training_id_code_r;
			end
			else if (pix_active_in)
			begin
				for (int i = 0; i < otp_pkg::LANES; i++)
					lanes_nxt[i*LW +: LW] = lane_word[i];
			end
			else
			begin
				for (int i = 0; i < otp_pkg::LANES; i++)
					lanes_nxt[i*LW +: LW] = training_word_in;
				sync_nxt = training_id_code_r;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			lane_data_out <= '0;
			sync_data_out <= '0;
		end
		else if (word_tick)
		begin
			lane_data_out <= lanes_nxt;
			sync_data_out <= sync_nxt;
		end
	end

endmodule : otp_top

// ### rtl/otp_pkg.sv
// constants for the output test-pattern and sync-status block
// assumes a 16-bit register port and 10-bit words on four data lanes
package otp_pkg;

	// =====================================================
	// geometry
	localparam int LANES = 4;
	localparam int WORD_W = 10;
	localparam int REG_W = 16;
	localparam int ADDR_W = 9;
	localparam int CHANS = 8;

	// =====================================================
	// register addresses
	localparam logic [8:0] ADDR_TRAIN_ID = 9'h087;
	localparam logic [8:0] ADDR_BLACK_ERR = 9'h088;
	localparam logic [8:0] ADDR_RSVD_STAT_A = 9'h089;
	localparam logic [8:0] ADDR_RSVD_STAT_B = 9'h08a;
	localparam logic [8:0] ADDR_RSVD_STAT_C = 9'h08b;
	localparam logic [8:0] ADDR_RSVD_CTRL_A = 9'h08c;
	localparam logic [8:0] ADDR_RSVD_CTRL_B = 9'h08d;
	localparam logic [8:0] ADDR_PAT_CTRL = 9'h090;
	localparam logic [8:0] ADDR_RSVD_CTRL_C = 9'h091;
	localparam logic [8:0] ADDR_PAT_LOW_01 = 9'h092;
	localparam logic [8:0] ADDR_PAT_LOW_23 = 9'h093;
	localparam logic [8:0] ADDR_PAT_HIGH = 9'h096;

	// =====================================================
	// reset values
	localparam logic [9:0] RST_TRAIN_ID = 10'h3a6;
	localparam logic [15:0] RST_RSVD_CTRL_A = 16'h0000;
	localparam logic [15:0] RST_RSVD_CTRL_B = 16'hffff;
	localparam logic [15:0] RST_RSVD_CTRL_C = 16'h0000;
	localparam logic [15:0] RST_PAT_LOW_01 = 16'h0100;
	localparam logic [15:0] RST_PAT_LOW_23 = 16'h0302;
	localparam logic [7:0] RST_PAT_HIGH = 8'h00;
	localparam logic [3:0] RST_PAT_CTRL = 4'h0;

	// =====================================================
	// pattern_control fields
	localparam int BIT_PAT_EN = 0;
	localparam int BIT_PAT_INC = 1;
	localparam int BIT_PRBS_EN = 2;
	localparam int BIT_PAT_FRAMED = 3;
	localparam int PAT_CTRL_W = 4;

	// =====================================================
	// prbs: x^15 + x^14 + 1
	localparam int LFSR_W = 15;
	localparam int LFSR_TAP_A = 14;
	localparam int LFSR_TAP_B = 13;
	localparam logic [4:0] LFSR_SEED_TOP = 5'h1f;

	typedef enum logic [1:0] {
		OTP_MODE_CONST,
		OTP_MODE_INC,
		OTP_MODE_PRBS
	} otp_mode_e;

endpackage : otp_pkg

// ### rtl/otp_lane_if.sv
// carrier between the pattern control and one lane generator
// assumes both ends run on clk_in
`timescale 1ns/1ps
interface otp_lane_if;
	otp_pkg::otp_mode_e mode;
	logic [otp_pkg::WORD_W-1:0] base;
	logic step;
	logic restart;
	logic [otp_pkg::WORD_W-1:0] word;

	modport ctrl (
		output mode,
		output base,
		output step,
		output restart,
		input word
	);
	modport gen (
		input mode,
		input base,
		input step,
		input restart,
		output word
	);
endinterface : otp_lane_if

// ### rtl/otp_lane_gen.sv
// one lane's synthesized word: constant, incrementing or prbs
// assumes step and restart are one-cycle pulses on clk_in
`timescale 1ns/1ps
module otp_lane_gen (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// control and word
	otp_lane_if.gen lane
);

	logic [otp_pkg::WORD_W-1:0] cnt_r;
	logic [otp_pkg::LFSR_W-1:0] lfsr_r;
	logic [otp_pkg::LFSR_W-1:0] seed;

	assign seed = {otp_pkg::LFSR_SEED_TOP, lane.base};

	// =====================================================
	// incrementing counter, reloads from the lane value
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			cnt_r <= '0;
		else if (lane.restart)
			cnt_r <= lane.base;
		else if (lane.step)
			cnt_r <= cnt_r + 10'h001;
	end

	// =====================================================
	// prbs, seed never all zero
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			lfsr_r <= '1;
		else if (lane.restart)
			lfsr_r <= seed;
		else if (lane.step)
			lfsr_r <= {lfsr_r[otp_pkg::LFSR_W-2:0],
				lfsr_r[otp_pkg::LFSR_TAP_A] ^ lfsr_r[otp_pkg::LFSR_TAP_B]};
	end

	always_comb
	begin
		unique case (lane.mode)
			otp_pkg::OTP_MODE_INC: lane.word = cnt_r;
			otp_pkg::OTP_MODE_PRBS: lane.word = lfsr_r[otp_pkg::WORD_W-1:0];
			otp_pkg::OTP_MODE_CONST: lane.word = lane.base;
			default: lane.word = lane.base;
		endcase
	end

endmodule : otp_lane_gen

// ### tb/otp_top_properties.sv
// port checker for the test-pattern and sync-status block
// assumes it is bound onto otp_top
`timescale 1ns/1ps
module otp_top_properties (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [8:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic [7:0] black_cal_err_in,
	// stream and link
	input wire logic [39:0] pix_words_in,
	input wire logic [9:0] pix_sync_in,
	input wire logic word_take_out,
	input wire logic link_clk_in,
	input wire logic [39:0] lane_data_out,
	input wire logic [9:0] sync_data_out
);
	// ==========
	// shadow of the written control and training id
	logic [3:0] ctrl_r;
	logic [9:0] tid_r;
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			ctrl_r <= 4'h0;
			tid_r <= 10'h3a6;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == otp_pkg::ADDR_PAT_CTRL)
				ctrl_r <= reg_wdata_in[3:0];
			if (reg_addr_in == otp_pkg::ADDR_TRAIN_ID)
				tid_r <= reg_wdata_in[9:0];
		end
	end

	// ==========
	// properties
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_link_rise;
		!link_clk_in ##1 link_clk_in;
	endsequence
	sequence s_take;
		word_take_out ##1 !word_take_out;
	endsequence

	a_rvalid_after_rd: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read not answered");
	a_rvalid_only_rd: assert property (!reg_rd_in |=> !reg_rvalid_out)
		else $error("read answer without request");
	a_take_follows_link: assert property (s_link_rise |-> ##[2:5] s_take)
		else $error("link edge gave no single word take");
	a_lanes_hold: assert property (!word_take_out |=> $stable(lane_data_out) && $stable(sync_data_out))
		else $error("lane output moved outside a word take");
	a_pass_through: assert property (word_take_out && !ctrl_r[0] && !ctrl_r[2]
		|=> lane_data_out == $past(pix_words_in) && sync_data_out == $past(pix_sync_in))
		else $error("pixel data altered with patterns off");
	a_sync_training: assert property (word_take_out && (ctrl_r[0] || ctrl_r[2]) && !ctrl_r[3]
		|=> sync_data_out == $past(tid_r))
		else $error("unframed sync word is not the training id");
	a_flags_read: assert property (reg_rd_in && reg_addr_in == otp_pkg::ADDR_BLACK_ERR
		&& !$past(sys_rst_in) |=> reg_rdata_out == {8'h00, $past(black_cal_err_in, 2)})
		else $error("error flags read wrong");
	a_train_read: assert property (reg_rd_in && reg_addr_in == otp_pkg::ADDR_TRAIN_ID
		|=> reg_rdata_out == {6'h00, $past(tid_r)})
		else $error("training id read wrong");
	a_ctrl_read: assert property (reg_rd_in && reg_addr_in == otp_pkg::ADDR_PAT_CTRL
		|=> reg_rdata_out == {12'h000, $past(ctrl_r)})
		else $error("pattern control read wrong");
	a_unmapped_zero: assert property (reg_rd_in
		&& (reg_addr_in > otp_pkg::ADDR_PAT_HIGH || reg_addr_in inside {9'h094, 9'h095})
		|=> reg_rdata_out == 16'h0000)
		else $error("unmapped read not zero");
endmodule : otp_top_properties

bind otp_top otp_top_properties i_otp_top_properties (.clk_in, .sys_rst_in, .reg_addr_in,
	.reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .black_cal_err_in,
	.pix_words_in, .pix_sync_in, .word_take_out, .link_clk_in, .lane_data_out, .sync_data_out);

// ### tb/otp_rx_model.sv
// receiver model: word alignment on the idle training word
// assumes lanes update at the edge that ends a word take
`timescale 1ns/1ps
module otp_rx_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// lanes from the block
	input wire logic word_take_in,
	input wire logic [39:0] lane_data_in,
	input wire logic [9:0] training_word_in,
	// alignment result
	output logic aligned_out
);
	logic take_d_r;
	always_ff @(posedge clk_in)
	begin
		take_d_r <= word_take_in;
		if (sys_rst_in)
			aligned_out <= 1'b0;
		else if (take_d_r)
			aligned_out <= lane_data_in == {4{training_word_in}};
	end
endmodule : otp_rx_model

// ### tb/otp_top_tb_top.sv
// self-checking bench for otp_top
// assumes the checker bind and the receiver model are compiled
`timescale 1ns/1ps
module otp_top_tb_top;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic link_clk = 1'b0;
	logic [8:0] addr = 9'h000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [7:0] err = 8'h00;
	logic [9:0] trw = 10'h000;
	logic [39:0] pix = 40'h0;
	logic [9:0] psync = 10'h000;
	logic act = 1'b0;
	logic fst = 1'b0;
	logic [15:0] rdata;
	logic rvalid;
	logic take;
	logic [39:0] lanes;
	logic [9:0] sync;
	logic aligned;
	logic pend = 1'b0;
	logic [9:0] tid = 10'h3a6;
	logic [15:0] rq[$];
	logic [49:0] lq[$];
	int bad_count = 0;
	int n_tests = 0;

	otp_top i_otp_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .black_cal_err_in(err), .training_word_in(trw),
		.pix_words_in(pix), .pix_sync_in(psync), .pix_active_in(act),
		.pix_frame_start_in(fst), .word_take_out(take), .link_clk_in(link_clk),
		.lane_data_out(lanes), .sync_data_out(sync));
	otp_rx_model i_otp_rx_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .word_take_in(take),
		.lane_data_in(lanes), .training_word_in(trw), .aligned_out(aligned));

	always #5 clk_in = ~clk_in;
	initial
	begin
		#13;
		forever #40 link_clk = ~link_clk;
	end

	// ==========
	// compare and closing
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp16
	task automatic cmp50(input logic [49:0] g, input logic [49:0] e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp50
	task automatic close_out;
		bad_count += rq.size() + lq.size();
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	always @(negedge clk_in)
	begin
		if (rvalid === 1'b1 && rq.size() > 0)
			cmp16(rdata, rq.pop_front());
		if (pend && lq.size() > 0)
			cmp50({sync, lanes}, lq.pop_front());
		pend = (take === 1'b1);
	end

	// ==========
	// drivers
	task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
		@(negedge clk_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_in);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [8:0] a, input logic [15:0] e);
		@(negedge clk_in);
		addr = a;
		rd = 1'b1;
		rq.push_back(e);
		@(negedge clk_in);
		rd = 1'b0;
	endtask : rd_reg
	// thru[0]: lanes expected from pix, thru[1]: sync expected from psync
	task automatic word(input logic [1:0] thru, input logic [49:0] e);
		int k;
		for (k = 0; k < 40 && take !== 1'b1; k++)
			@(negedge clk_in);
		pix = 40'({$urandom(), $urandom()});
		psync = 10'($urandom());
		lq.push_back({thru[1] ? psync : e[49:40], thru[0] ? pix : e[39:0]});
		@(negedge clk_in);
	endtask : word

	initial
	begin
		#100us;
		bad_count++;
		close_out();
	end

	initial
	begin
		logic [8:0] ra[13] = '{9'h087, 9'h088, 9'h089, 9'h08a, 9'h08b, 9'h08c, 9'h08d,
			9'h090, 9'h091, 9'h092, 9'h093, 9'h096, 9'h094};
		logic [15:0] rv[13] = '{16'h03a6, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff,
			16'h0, 16'h0, 16'h0100, 16'h0302, 16'h0, 16'h0};
		logic [8:0] wa[7] = '{9'h087, 9'h08c, 9'h08d, 9'h090, 9'h091, 9'h096, 9'h094};
		logic [15:0] wm[7] = '{16'h03ff, 16'hffff, 16'hffff, 16'h000f, 16'hffff, 16'h00ff, 16'h0};
		logic [3:0] ctl[5] = '{4'h1, 4'h3, 4'h4, 4'h9, 4'hb};
		logic [9:0] v[4];
		logic [14:0] s[4];
		logic [49:0] e;
		logic [15:0] d;
		logic [3:0] c;
		int i, k, m, j;
		void'($urandom(57));
		repeat (10) @(negedge clk_in);
		sys_rst_in = 1'b0;
		for (i = 0; i < 13; i++)
			rd_reg(ra[i], rv[i]);
		for (i = 0; i < 7; i++)
		begin
			d = 16'($urandom());
			wr_reg(wa[i], d);
			rd_reg(wa[i], d & wm[i]);
		end
		wr_reg(otp_pkg::ADDR_TRAIN_ID, 16'h0155);
		tid = 10'h155;
		wr_reg(otp_pkg::ADDR_PAT_CTRL, 16'h0000);
		err = 8'($urandom());
		wr_reg(otp_pkg::ADDR_BLACK_ERR, 16'hffff);
		rd_reg(otp_pkg::ADDR_BLACK_ERR, {8'h00, err});
		for (m = 0; m < 5; m++)
		begin
			c = ctl[m];
			for (i = 0; i < 4; i++)
				v[i] = 10'($urandom());
			wr_reg(otp_pkg::ADDR_PAT_LOW_01, {v[1][7:0], v[0][7:0]});
			wr_reg(otp_pkg::ADDR_PAT_LOW_23, {v[3][7:0], v[2][7:0]});
			wr_reg(otp_pkg::ADDR_PAT_HIGH, {8'h00, v[3][9:8], v[2][9:8], v[1][9:8], v[0][9:8]});
			trw = 10'($urandom());
			word(2'b11, 50'h0);
			wr_reg(otp_pkg::ADDR_PAT_CTRL, {12'h000, c});
			for (i = 0; i < 4; i++)
				s[i] = {5'h1f, v[i]};
			j = 0;
			for (k = 0; k < 4; k++)
			begin
				// framed run: idle word with frame start restarts the count
				act = (c == 4'hb) && (k != 1);
				fst = (c == 4'hb) && (k == 1);
				for (i = 0; i < 4; i++)
				begin
					e[10*i +: 10] = (c[3] && !act) ? trw : c[2] ? s[i][9:0] :
						c[1] ? v[i] + 10'(j) : v[i];
					s[i] = {s[i][13:0], s[i][14] ^ s[i][13]};
				end
				e[49:40] = tid;
				word({c[3] && act, 1'b0}, e);
				j = fst ? 0 : j + 1;
			end
			@(negedge clk_in);
			if (c == 4'h9)
				cmp16({15'h0000, aligned}, 16'h0001);
			wr_reg(otp_pkg::ADDR_PAT_CTRL, 16'h0000);
		end
		repeat (4) @(negedge clk_in);
		close_out();
	end
endmodule : otp_top_tb_top
